// ===== mtt_bus_if.sv
`timescale 1ns/100ps
interface mtt_bus_if;
    logic       tick;
    logic [9:0] count;
    logic       match_pulse;
    modport timer (input tick, output count, output match_pulse);
    modport core  (output tick, input count, input match_pulse);
endinterface

// ===== mtt_counter.sv
`timescale 1ns/100ps
module mtt_counter (
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        run_in,
    input  wire logic        load_next_in,
    input  wire logic [9:0]  next_wr_in,
    input  wire logic        load_match_in,
    input  wire logic [9:0]  match_wr_in,
    output logic      [9:0]  match_out,
    output logic      [9:0]  next_out,
    mtt_bus_if.timer         bus
);
    logic [9:0] count_reg;
    logic       pulse_reg;

    assign bus.count       = count_reg;
    assign bus.match_pulse = pulse_reg;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_reg <= 10'h000;
        end else if (run_in && bus.tick) begin
            count_reg <= count_reg + 10'h001;
        end
    end

    // A match fires once, on the tick that leaves the matching count.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pulse_reg <= 1'b0;
        end else begin
            pulse_reg <= run_in && bus.tick && (count_reg == match_out);
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            match_out <= 10'h000;
        end else if (load_match_in) begin
            match_out <= match_wr_in;
        end else if (run_in && bus.tick && (count_reg == match_out)) begin
            match_out <= load_next_in ? next_wr_in : next_out;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            next_out <= 10'h000;
        end else if (load_next_in) begin
            next_out <= next_wr_in;
        end
    end
endmodule

// ===== mtt_pins_model.sv
`timescale 1ns/100ps
module mtt_pins_model (
    input  wire logic       clk_in,
    input  wire logic [1:0] level_in,
    output logic      [1:0] pins_out
);
    // Pins move just after an edge, so sync delay is counted from a known clock.
    initial pins_out = 2'h0;
    always @(posedge clk_in) begin
        pins_out <= level_in;
    end
endmodule

// ===== mtt_pkg.sv
package mtt_pkg;
    localparam int         CNT_W        = 10;
    localparam int         OUT_W        = 8;
    localparam int         ADDR_W       = 4;
    localparam int         DATA_W       = 16;
    localparam logic [3:0] A_CTRL       = 4'h0;
    localparam logic [3:0] A_PRESCALE   = 4'h1;
    localparam logic [3:0] A_MATCH      = 4'h2;
    localparam logic [3:0] A_NEXT       = 4'h3;
    localparam logic [3:0] A_COUNT      = 4'h4;
    localparam logic [3:0] A_OUT_PREP   = 4'h5;
    localparam logic [3:0] A_OUT_NOW    = 4'h6;
    localparam logic [3:0] A_PINS       = 4'h7;
    localparam logic [3:0] A_STATUS     = 4'h8;
    localparam logic [3:0] A_MASK       = 4'h9;
    localparam int         CTRL_RUN     = 0;
    localparam int         CTRL_ERISE   = 1;
    localparam int         CTRL_EFALL   = 2;
    localparam int         ST_MATCH     = 0;
    localparam int         ST_EDGE      = 1;
    localparam int         ST_W         = 2;
    localparam int         LATENCY_CLKS = 30;
endpackage

// ===== mtt_top.sv
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/100ps
// Functional notes
// - Prepared output value moves to output pins only on the next match pulse.
// - A programmable match value makes a pulse when the counter reaches it.
// - On a match the active compare reloads from the next-match register.
// - The cascade lets successive matches lie one count apart.
// - Counter ticks at system clock over two, then over prescale 1 to 256.
// - Counter, match and next-match registers are all ten bits wide.
// - Output edges placeable at half the system clock rate.
// - External interrupt selectable on rising, falling or both edges.
// - Software can read the live count at any time.
// - Interrupt request reaches the core within thirty clocks of the event.
// - External interrupt is edge sensitive, never level sensitive.
// - Interrupt pin levels stay readable through the input port.
module mtt_top (
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic [3:0]  addr_in,
    input  wire logic [15:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [15:0] rdata_out,
    input  wire logic [1:0]  ext_int_in,
    output logic      [7:0]  port_out,
    output logic             match_pulse_out,
    output logic             irq_out
);
    mtt_bus_if bus ();

    logic [2:0]  ctrl_reg;
    logic [7:0]  prescale_reg;
    logic [7:0]  div_reg;
    logic        half_reg;
    logic        tick_reg;
    logic [7:0]  prep_reg;
    logic [1:0]  sync1_reg;
    logic [1:0]  sync2_reg;
    logic [1:0]  prev_reg;
    logic [1:0]  status_reg;
    logic [1:0]  mask_reg;
    logic [9:0]  match_val;
    logic [9:0]  next_val;
    logic [1:0]  edge_hit;
    logic        wr_ctrl;
    logic        wr_match;
    logic        wr_next;

    assign wr_ctrl  = wr_in && (addr_in == mtt_pkg::A_CTRL);
    assign wr_match = wr_in && (addr_in == mtt_pkg::A_MATCH);
    assign wr_next  = wr_in && (addr_in == mtt_pkg::A_NEXT);
    assign bus.tick = tick_reg;

    mtt_counter u_cnt (
        .clk_in        (clk_in),
        .rst_n_in      (rst_n_in),
        .run_in        (ctrl_reg[mtt_pkg::CTRL_RUN]),
        .load_next_in  (wr_next),
        .next_wr_in    (wdata_in[9:0]),
        .load_match_in (wr_match),
        .match_wr_in   (wdata_in[9:0]),
        .match_out     (match_val),
        .next_out      (next_val),
        .bus           (bus)
    );

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_reg     <= 3'h0;
            prescale_reg <= 8'h00;
            prep_reg     <= 8'h00;
            mask_reg     <= 2'h0;
        end else if (wr_in) begin
            if (addr_in == mtt_pkg::A_CTRL) begin
                ctrl_reg <= wdata_in[2:0];
            end
            if (addr_in == mtt_pkg::A_PRESCALE) begin
                prescale_reg <= wdata_in[7:0];
            end
            if (addr_in == mtt_pkg::A_OUT_PREP) begin
                prep_reg <= wdata_in[7:0];
            end
            if (addr_in == mtt_pkg::A_MASK) begin
                mask_reg <= wdata_in[1:0];
            end
        end
    end

    // Prescale value N divides by N+1, so 00 gives 1 and FF gives 256.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            half_reg <= 1'b0;
            div_reg  <= 8'h00;
            tick_reg <= 1'b0;
        end else if (wr_ctrl) begin
            half_reg <= 1'b0;
            div_reg  <= 8'h00;
            tick_reg <= 1'b0;
        end else begin
            half_reg <= ~half_reg;
            tick_reg <= 1'b0;
            if (half_reg) begin
                if (div_reg == prescale_reg) begin
                    div_reg  <= 8'h00;
                    tick_reg <= 1'b1;
                end else begin
                    div_reg <= div_reg + 8'h01;
                end
            end
        end
    end

    // The prepared value lands in hardware, so interrupt latency cannot skew the edge.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            port_out        <= 8'h00;
            match_pulse_out <= 1'b0;
        end else begin
            match_pulse_out <= bus.match_pulse;
            if (bus.match_pulse) begin
                port_out <= prep_reg;
            end else if (wr_in && (addr_in == mtt_pkg::A_OUT_NOW)) begin
                port_out <= wdata_in[7:0];
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync1_reg <= 2'h0;
            sync2_reg <= 2'h0;
            prev_reg  <= 2'h0;
        end else begin
            sync1_reg <= ext_int_in;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_edge
            assign edge_hit[g] =
                (ctrl_reg[mtt_pkg::CTRL_ERISE] && sync2_reg[g] && !prev_reg[g]) ||
                (ctrl_reg[mtt_pkg::CTRL_EFALL] && !sync2_reg[g] && prev_reg[g]);
        end
    endgenerate

    // Hardware set wins over a software clear in the same cycle.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            status_reg <= 2'h0;
        end else begin
            status_reg[mtt_pkg::ST_MATCH] <= bus.match_pulse ||
                (status_reg[mtt_pkg::ST_MATCH] &&
                 !(wr_in && addr_in == mtt_pkg::A_STATUS && wdata_in[mtt_pkg::ST_MATCH]));
            status_reg[mtt_pkg::ST_EDGE] <= (|edge_hit) ||
                (status_reg[mtt_pkg::ST_EDGE] &&
                 !(wr_in && addr_in == mtt_pkg::A_STATUS && wdata_in[mtt_pkg::ST_EDGE]));
        end
    end

    // Request reaches the core four clocks after the pin edge, well inside the budget.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(status_reg & mask_reg);
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_out <= 16'h0000;
        end else if (rd_in) begin
            unique case (addr_in)
                mtt_pkg::A_CTRL:     rdata_out <= {13'h0000, ctrl_reg};
                mtt_pkg::A_PRESCALE: rdata_out <= {8'h00, prescale_reg};
                mtt_pkg::A_MATCH:    rdata_out <= {6'h00, match_val};
                mtt_pkg::A_NEXT:     rdata_out <= {6'h00, next_val};
                mtt_pkg::A_COUNT:    rdata_out <= {6'h00, bus.count};
                mtt_pkg::A_OUT_PREP: rdata_out <= {8'h00, prep_reg};
                mtt_pkg::A_OUT_NOW:  rdata_out <= {8'h00, port_out};
                mtt_pkg::A_PINS:     rdata_out <= {14'h0000, sync2_reg};
                mtt_pkg::A_STATUS:   rdata_out <= {14'h0000, status_reg};
                mtt_pkg::A_MASK:     rdata_out <= {14'h0000, mask_reg};
                default:             rdata_out <= 16'h0000;
            endcase
        end else begin
            rdata_out <= 16'h0000;
        end
    end
endmodule

// ===== mtt_top_asserts.sv
`timescale 1ns/100ps
module mtt_top_asserts (
    input wire logic        clk_in,
    input wire logic        rst_n_in,
    input wire logic [3:0]  addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic        wr_in,
    input wire logic        rd_in,
    input wire logic [15:0] rdata_out,
    input wire logic [1:0]  ext_int_in,
    input wire logic [7:0]  port_out,
    input wire logic        match_pulse_out,
    input wire logic        irq_out
);
    localparam int LAT = 30;
    logic [1:0] mask_reg;
    logic       rise_reg;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // Shadow copies let the irq checks know what software enabled.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mask_reg <= 2'h0;
            rise_reg <= 1'h0;
        end else if (wr_in && addr_in == mtt_pkg::A_MASK) begin
            mask_reg <= wdata_in[1:0];
        end else if (wr_in && addr_in == mtt_pkg::A_CTRL) begin
            rise_reg <= wdata_in[mtt_pkg::CTRL_ERISE];
        end
    end
    pulse_width_a: assert property (match_pulse_out |=> !match_pulse_out)
        else $error("match pulse too long");
    rdata_idle_a: assert property (!rd_in |=> rdata_out == 16'h0)
        else $error("read data outside read slot");
    port_hold_a: assert property (!match_pulse_out &&
        !$past(wr_in && addr_in == mtt_pkg::A_OUT_NOW) |-> $stable(port_out))
        else $error("port changed without pulse");
    pins_read_a: assert property (rd_in && addr_in == mtt_pkg::A_PINS &&
        $stable(ext_int_in) && $past(ext_int_in) == $past(ext_int_in, 2)
        |=> rdata_out == {14'h0, $past(ext_int_in)})
        else $error("pin levels misread");
    irq_masked_a: assert property ($past(mask_reg) == 2'h0 |-> !irq_out)
        else $error("irq while all masked");
    match_irq_a: assert property (match_pulse_out && mask_reg[0] &&
        !(wr_in && addr_in == mtt_pkg::A_MASK) |=> irq_out)
        else $error("no irq after match");
    edge_irq_a: assert property ($rose(ext_int_in[0]) && rise_reg &&
        mask_reg[1] |-> ##[1:LAT] irq_out)
        else $error("edge irq late");
    count_width_a: assert property (rd_in && addr_in == mtt_pkg::A_COUNT
        |=> rdata_out[15:10] == 6'h0)
        else $error("count wider than ten bits");
    cover property (match_pulse_out ##2 match_pulse_out);
    cover property ($rose(irq_out));
    cover property (rd_in && addr_in == mtt_pkg::A_PINS);
endmodule

// ===== mtt_top_bench.sv
`timescale 1ns/100ps
module mtt_top_bench;
    logic        clk_in;
    logic        rst_n_in = 1'h0;
    logic [3:0]  addr_in = 4'h0;
    logic [15:0] wdata_in = 16'h0;
    logic        wr_in = 1'h0;
    logic        rd_in = 1'h0;
    logic [15:0] rdata_out;
    logic [1:0]  ext_int_in;
    logic [1:0]  level = 2'h0;
    logic [7:0]  port_out;
    logic        match_pulse_out;
    logic        irq_out;
    int          num_errors = 0;
    int          checks = 0;
    int          cycles = 0;
    logic [15:0] d;
    logic [15:0] c1;
    int          n;
    mtt_top dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .ext_int_in(ext_int_in), .port_out(port_out),
        .match_pulse_out(match_pulse_out), .irq_out(irq_out));
    mtt_pins_model pins_u (.clk_in(clk_in), .level_in(level), .pins_out(ext_int_in));
    initial begin
        clk_in = 1'h0;
        forever #5 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors = num_errors + 1;
            stop_test();
        end
    end
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= v;
        wr_in <= 1'h1;
        @(posedge clk_in);
        wr_in <= 1'h0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'h1;
        @(posedge clk_in);
        rd_in <= 1'h0;
        #1 d = rdata_out;
    endtask
    task automatic t_reset();
        rd(mtt_pkg::A_COUNT);
        check("count", d, 16'h0);
        rd(4'hF);
        check("unmapped", d, 16'h0);
        wr(mtt_pkg::A_OUT_NOW, 16'h3C);
        #1 check("port now", {8'h0, port_out}, 16'h3C);
        rd(mtt_pkg::A_OUT_NOW);
        check("port read", d, 16'h3C);
    endtask
    task automatic t_match();
        wr(mtt_pkg::A_PRESCALE, 16'h0);
        wr(mtt_pkg::A_MATCH, 16'h5);
        wr(mtt_pkg::A_NEXT, 16'h6);
        wr(mtt_pkg::A_OUT_PREP, 16'hA5);
        wr(mtt_pkg::A_MASK, 16'h1);
        wr(mtt_pkg::A_CTRL, 16'h1);
        for (n = 0; n < 100 && match_pulse_out !== 1'h1; n++) begin
            @(posedge clk_in);
            #1;
        end
        check("port", {8'h0, port_out}, 16'hA5);
        for (n = 1; n < 9; n++) begin
            @(posedge clk_in);
            #1;
            if (match_pulse_out === 1'h1) break;
        end
        check("gap", n[15:0], 16'h2);
        @(posedge clk_in);
        #1 check("irq", {15'h0, irq_out}, 16'h1);
        wr(mtt_pkg::A_CTRL, 16'h0);
        rd(mtt_pkg::A_MATCH);
        check("reload", d, 16'h6);
        rd(mtt_pkg::A_NEXT);
        check("next", d, 16'h6);
        wr(mtt_pkg::A_STATUS, 16'h3);
        rd(mtt_pkg::A_STATUS);
        check("status", d, 16'h0);
    endtask
    task automatic t_prescale();
        wr(mtt_pkg::A_PRESCALE, 16'h3);
        wr(mtt_pkg::A_CTRL, 16'h1);
        rd(mtt_pkg::A_COUNT);
        c1 = d;
        repeat (78) @(posedge clk_in);
        rd(mtt_pkg::A_COUNT);
        check("ticks", (d - c1) & 16'h3FF, 16'hA);
        wr(mtt_pkg::A_CTRL, 16'h0);
    endtask
    task automatic t_edge();
        logic [5:0] exp;
        exp = 6'h39;
        wr(mtt_pkg::A_MASK, 16'h2);
        wr(mtt_pkg::A_STATUS, 16'h3);
        for (int i = 0; i < 6; i++) begin
            wr(mtt_pkg::A_CTRL, 16'(2 * (i / 2 + 1)));
            level <= {1'h0, ~i[0]};
            for (n = 0; n < 30 && irq_out !== 1'h1; n++) begin
                @(posedge clk_in);
                #1;
            end
            check("edge irq", {15'h0, irq_out}, {15'h0, exp[i]});
            rd(mtt_pkg::A_PINS);
            check("pins", d, {15'h0, ~i[0]});
            wr(mtt_pkg::A_STATUS, 16'h2);
        end
    endtask
    task automatic stop_test();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk_in);
        rst_n_in <= 1'h1;
        t_reset();
        t_match();
        t_prescale();
        t_edge();
        stop_test();
    end
endmodule
bind mtt_top mtt_top_asserts chk_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .ext_int_in(ext_int_in), .port_out(port_out),
    .match_pulse_out(match_pulse_out), .irq_out(irq_out));
